// *** hdl/ecn_card_steer.sv ***
module ecn_card_steer (
    ecn_smc_if.sink smc,                  // Controller strobes and address
    input wire logic cs4_assign,          // Slot 0 owns chip select four
    input wire logic cs5_assign,          // Slot 1 owns chip select five
    output logic card_access,             // A card slot select is active
    output ecn_pkg::ecn_card_mode_t mode, // Decoded card mode
    output logic oe_n,                    // Card memory output enable
    output logic we_n,                    // Card memory write enable
    output logic ior_n,                   // Card I/O read
    output logic iow_n,                   // Card I/O write
    output logic ce1_n,                   // Card enable one
    output logic ce2_n,                   // Card enable two
    output logic reg_n                    // Card register select
);
    import ecn_pkg::*;
    logic slot_sel_n;

    always_comb begin
        slot_sel_n = ~((cs4_assign & ~smc.cs_n[CS_CARD0]) | (cs5_assign & ~smc.cs_n[CS_CARD1]));
        card_access = ~slot_sel_n;
        mode = ecn_decode_mode(smc.addr[MODE_MSB:MODE_LSB]);
        oe_n = RST_STROBE_N;
        we_n = RST_STROBE_N;
        ior_n = RST_STROBE_N;
        iow_n = RST_STROBE_N;
        ce1_n = 1'b1;
        ce2_n = 1'b1;
        reg_n = smc.addr[REG_SEL_BIT];
        unique case (mode)
            ecn_mode_attr, ecn_mode_common: begin
                oe_n = smc.rd_n;
                we_n = smc.wr0_n;
                ce1_n = smc.bs0_n;
                ce2_n = smc.wr1_n;
            end
            ecn_mode_io: begin
                ior_n = smc.rd_n;
                iow_n = smc.wr0_n;
                ce1_n = smc.bs0_n;
                ce2_n = smc.wr1_n;
            end
            ecn_mode_ide, ecn_mode_alt_ide: begin
                oe_n = 1'b0;
                we_n = 1'b1;
                ior_n = smc.rd_n;
                iow_n = smc.wr0_n;
                reg_n = 1'b1;
                ce1_n = (mode == ecn_mode_alt_ide);
                ce2_n = (mode == ecn_mode_ide);
            end
            ecn_mode_none: begin
                reg_n = 1'b1;
            end
        endcase
        // Enables only move inside the slot select window
        ce1_n = ce1_n | slot_sel_n;
        ce2_n = ce2_n | slot_sel_n;
    end
endmodule

// *** hdl/ecn_flash_steer.sv ***
module ecn_flash_steer (
    ecn_smc_if.sink smc,     // Controller strobes and address
    input wire logic assign_en, // Chip select three owned by flash
    output logic active,     // Flash access in progress
    output logic oe_n,       // Flash output enable
    output logic we_n,       // Flash write enable
    output logic ale,        // Flash address latch enable
    output logic cle         // Flash command latch enable
);
    import ecn_pkg::*;

    always_comb begin
        active = assign_en & ~smc.cs_n[CS_FLASH]
            & ecn_in_flash_region(smc.bus_addr);
        oe_n = active ? smc.rd_n : RST_STROBE_N;
        we_n = active ? smc.wr0_n : RST_STROBE_N;
        ale = assign_en & smc.addr[ALE_BIT];
        cle = assign_en & smc.addr[CLE_BIT];
    end
endmodule

// *** hdl/ecn_pin_steering.sv ***
module ecn_pin_steering (
    input wire logic clock,                               // System bus clock
    input wire logic reset,                               // Async reset, high
    input wire logic cs1_dram_assign_bit,                 // Chip select 1 to DRAM
    input wire logic cs3_flash_assign_bit,                // Chip select 3 to flash
    input wire logic cs4_card_assign_bit,                 // Chip select 4 to slot 0
    input wire logic cs5_card_assign_bit,                 // Chip select 5 to slot 1
    input wire logic [ecn_pkg::NUM_CS-1:0] smc_cs_n,      // Controller chip selects
    input wire logic dram_cs_n,                           // DRAM controller select
    input wire logic static_read_strobe_n,                // Controller read strobe
    input wire logic static_write0_strobe_n,              // Controller write 0
    input wire logic static_write1_byte1_select_n,        // Controller write 1 / byte 1
    input wire logic static_write3_byte3_select_n,        // Controller write 3 / byte 3
    input wire logic static_byte0_select_n,               // Controller byte 0 select
    input wire logic transfer_write,                      // Transfer is a write
    input wire logic [ecn_pkg::ADDR_W-1:0] smc_address,   // External address
    input wire logic [ecn_pkg::BUS_ADDR_W-1:0] bus_address, // System transfer address
    input wire logic cs0_mode_load,                       // Load chip select 0 mode
    input wire logic cs0_byte_select_in,                  // New byte select mode
    input wire logic [1:0] cs0_bus_width_in,              // New bus width code
    input wire logic cs0_rw_by_cs_in,                     // New read/write by select
    output logic [ecn_pkg::NUM_CS-1:0] chip_select_n,     // Chip select pins
    output logic read_or_card_oe_n,                       // Read / card memory OE pin
    output logic write0_or_card_we_n,                     // Write 0 / card memory WE pin
    output logic write1_or_card_ior_n,                    // Write 1 / card I/O read pin
    output logic write3_or_card_iow_n,                    // Write 3 / card I/O write pin
    output logic addr25_or_card_rnw,                      // A25 / card read-not-write pin
    output logic [ecn_pkg::ADDR_W-2:0] address_out,       // Address pins below A25
    output logic card_enable_one_n,                       // Card enable one
    output logic card_enable_two_n,                       // Card enable two
    output logic card_register_select_n,                  // Card register select
    output logic flash_output_enable_n,                   // Flash output enable
    output logic flash_write_enable_n,                    // Flash write enable
    output logic flash_addr_latch,                        // Flash address latch
    output logic flash_cmd_latch,                         // Flash command latch
    output logic cs0_byte_select_mode,                    // Boot select byte mode
    output logic [1:0] cs0_bus_width,                     // Boot select width code
    output logic cs0_rw_by_chip_select                    // Boot select read/write style
);
    import ecn_pkg::*;

    ecn_smc_if smc ();
    ecn_card_mode_t card_mode;
    logic card_access;
    logic card_oe_n;
    logic card_we_n;
    logic card_ior_n;
    logic card_iow_n;
    logic card_ce1_n;
    logic card_ce2_n;
    logic card_reg_n;
    logic flash_active;
    logic flash_oe_n;
    logic flash_we_n;
    logic flash_ale;
    logic flash_cle;
    logic card_rnw;
    logic next_card_rnw;
    logic [NUM_CS-1:0] next_cs_n;

    assign smc.cs_n = smc_cs_n;
    assign smc.rd_n = static_read_strobe_n;
    assign smc.wr0_n = static_write0_strobe_n;
    assign smc.wr1_n = static_write1_byte1_select_n;
    assign smc.wr3_n = static_write3_byte3_select_n;
    assign smc.bs0_n = static_byte0_select_n;
    assign smc.write = transfer_write;
    assign smc.addr = smc_address;
    assign smc.bus_addr = bus_address;

    ecn_card_steer u_card (
        .smc(smc.sink),
        .cs4_assign(cs4_card_assign_bit),
        .cs5_assign(cs5_card_assign_bit),
        .card_access(card_access),
        .mode(card_mode),
        .oe_n(card_oe_n),
        .we_n(card_we_n),
        .ior_n(card_ior_n),
        .iow_n(card_iow_n),
        .ce1_n(card_ce1_n),
        .ce2_n(card_ce2_n),
        .reg_n(card_reg_n)
    );

    ecn_flash_steer u_flash (
        .smc(smc.sink),
        .assign_en(cs3_flash_assign_bit),
        .active(flash_active),
        .oe_n(flash_oe_n),
        .we_n(flash_we_n),
        .ale(flash_ale),
        .cle(flash_cle)
    );

    // Direction follows the controller while a card is selected and holds between
    assign next_card_rnw = card_access ? ~transfer_write : card_rnw;

    always_comb begin
        next_cs_n = smc_cs_n;
        // Card selects pass the chip select waveform unchanged
        next_cs_n[CS_CARD0] = smc_cs_n[CS_CARD0];
        next_cs_n[CS_CARD1] = smc_cs_n[CS_CARD1];
        next_cs_n[CS_DRAM] = cs1_dram_assign_bit ? dram_cs_n : smc_cs_n[CS_DRAM];
    end

    // All pins are registered together so their mutual timing is kept
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            chip_select_n <= RST_CS_N;
        end else begin
            chip_select_n <= next_cs_n;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            read_or_card_oe_n <= RST_STROBE_N;
            write0_or_card_we_n <= RST_STROBE_N;
            write1_or_card_ior_n <= RST_STROBE_N;
            write3_or_card_iow_n <= RST_STROBE_N;
            addr25_or_card_rnw <= 1'b0;
            address_out <= '0;
        end else begin
            read_or_card_oe_n <= card_access ? card_oe_n : static_read_strobe_n;
            write0_or_card_we_n <= card_access ? card_we_n : static_write0_strobe_n;
            write1_or_card_ior_n <= card_access ? card_ior_n
                : static_write1_byte1_select_n;
            write3_or_card_iow_n <= card_access ? card_iow_n
                : static_write3_byte3_select_n;
            addr25_or_card_rnw <= card_access ? next_card_rnw
                : smc_address[A25_BIT];
            address_out <= smc_address[ADDR_W-2:0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            card_rnw <= 1'b1;
            card_enable_one_n <= 1'b1;
            card_enable_two_n <= 1'b1;
            card_register_select_n <= 1'b1;
        end else begin
            card_rnw <= next_card_rnw;
            card_enable_one_n <= card_ce1_n;
            card_enable_two_n <= card_ce2_n;
            card_register_select_n <= card_reg_n;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            flash_output_enable_n <= RST_STROBE_N;
            flash_write_enable_n <= RST_STROBE_N;
            flash_addr_latch <= 1'b0;
            flash_cmd_latch <= 1'b0;
        end else begin
            flash_output_enable_n <= flash_oe_n;
            flash_write_enable_n <= flash_we_n;
            flash_addr_latch <= flash_ale;
            flash_cmd_latch <= flash_cle;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cs0_byte_select_mode <= RST_CS0_BYTE_SELECT;
            cs0_bus_width <= RST_CS0_WIDTH;
            cs0_rw_by_chip_select <= RST_CS0_RW_BY_CS;
        end else if (cs0_mode_load) begin
            cs0_byte_select_mode <= cs0_byte_select_in;
            cs0_bus_width <= cs0_bus_width_in;
            cs0_rw_by_chip_select <= cs0_rw_by_cs_in;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    logic boot_untouched;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            boot_untouched <= 1'b1;
        end else if (cs0_mode_load) begin
            boot_untouched <= 1'b0;
        end
    end

    a_io_mode_strobes: assert property (
        card_access && card_mode == ecn_mode_io |=>
        write1_or_card_ior_n == $past(static_read_strobe_n) && read_or_card_oe_n)
        else $error("I/O mode strobes misrouted");
    a_mem_mode_strobes: assert property (
        card_access && (card_mode == ecn_mode_attr || card_mode == ecn_mode_common) |=>
        read_or_card_oe_n == $past(static_read_strobe_n)
        && write0_or_card_we_n == $past(static_write0_strobe_n)
        && write1_or_card_ior_n && write3_or_card_iow_n)
        else $error("Memory mode strobes misrouted");
    a_ide_fixed_pins: assert property (
        card_access && card_mode == ecn_mode_ide |=>
        !read_or_card_oe_n && write0_or_card_we_n
        && write3_or_card_iow_n == $past(static_write0_strobe_n))
        else $error("True IDE fixed pins wrong");
    a_card_select_pass: assert property (
        cs4_card_assign_bit |=> chip_select_n[CS_CARD0] == $past(smc_cs_n[CS_CARD0]))
        else $error("Card slot select not passed");
    a_shared_normal: assert property (
        !card_access |=> read_or_card_oe_n == $past(static_read_strobe_n)
        && write3_or_card_iow_n == $past(static_write3_byte3_select_n)
        && addr25_or_card_rnw == $past(smc_address[A25_BIT]))
        else $error("Shared pins wrong outside card access");
    a_slot0_timing: assert property (
        $fell(smc_cs_n[CS_CARD0]) |=> $fell(chip_select_n[CS_CARD0]))
        else $error("Slot 0 select edge misplaced");
    a_rnw_stable: assert property (
        card_access && $past(card_access) && $stable(transfer_write) |=>
        $stable(addr25_or_card_rnw))
        else $error("Card direction moved mid transfer");
    a_flash_region: assert property (
        cs3_flash_assign_bit && !smc_cs_n[CS_FLASH] && ecn_in_flash_region(bus_address)
        && !static_read_strobe_n |=> !flash_output_enable_n)
        else $error("Flash region access not steered");
    a_flash_write: assert property (
        flash_active |=> flash_write_enable_n == $past(static_write0_strobe_n))
        else $error("Flash write strobe misrouted");
    a_flash_drop: assert property (
        !ecn_in_flash_region(bus_address) |=> flash_output_enable_n && flash_write_enable_n)
        else $error("Flash strobes held outside region");
    a_flash_latches: assert property (
        cs3_flash_assign_bit |=> flash_addr_latch == $past(smc_address[ALE_BIT])
        && flash_cmd_latch == $past(smc_address[CLE_BIT]))
        else $error("Flash latch enables wrong");
    a_boot_default: assert property (
        boot_untouched |-> cs0_byte_select_mode && cs0_bus_width == DBW_16
        && cs0_rw_by_chip_select)
        else $error("Boot chip select mode not default");
    a_dram_select: assert property (
        cs1_dram_assign_bit |=> chip_select_n[CS_DRAM] == $past(dram_cs_n))
        else $error("Chip select 1 not given to DRAM");
    a_alt_ide_decode: assert property (
        card_access && smc_address[MODE_MSB:MODE_LSB] == MODE_ALT_IDE |=>
        card_enable_one_n && !card_enable_two_n && card_register_select_n)
        else $error("Card mode decode wrong");
    a_reg_select: assert property (
        card_mode == ecn_mode_io |=>
        card_register_select_n == $past(smc_address[REG_SEL_BIT]))
        else $error("Register select not from bit 22");
    a_enable_window: assert property (
        !card_access |=> card_enable_one_n && card_enable_two_n)
        else $error("Card enable outside select window");
    a_slot1_select: assert property (
        cs5_card_assign_bit |=> chip_select_n[CS_CARD1] == $past(smc_cs_n[CS_CARD1]))
        else $error("Card slot 1 select not passed");
    a_card_mode_idle: assert property (
        card_access && card_mode == ecn_mode_none |=> read_or_card_oe_n
        && write0_or_card_we_n && write1_or_card_ior_n && write3_or_card_iow_n)
        else $error("Undefined card mode not idle");

    c_card_io_read: cover property (
        card_access && card_mode == ecn_mode_io && !static_read_strobe_n);
    c_card_mem_write: cover property (
        card_access && card_mode == ecn_mode_common && !static_write0_strobe_n);
    c_card_ide: cover property (card_access && card_mode == ecn_mode_ide);
    c_flash_command: cover property (flash_active && smc_address[CLE_BIT]);
    c_card_slot1: cover property (card_access && !smc_cs_n[CS_CARD1]);
endmodule

// *** hdl/ecn_pkg.sv ***
// How it works
// - I/O and True IDE modes put controller strobes on card I/O pins only.
// - Memory modes put controller strobes on card memory pins; I/O pins stay idle.
// - Card assign bit dedicates chip select four or five to a card slot.
// - Shared pins carry card signals on card access, normal signals otherwise.
// - Card slot 0 select follows chip select four exactly.
// - Card read/not-write stays valid throughout the transfer.
// - Flash assign bit enables flash logic for the 0x4000_0000 region.
// - While chip select three is active with the address in the flash region, strobes go to flash pins.
// - Flash strobes drop at once when address leaves chip select three space.
// - Flash address and command latches come from address bits 21 and 22.
// - Chip select 0 resets to byte select, 16-bit, read/write by chip select.
// - DRAM assign bit gives chip select 1 to the DRAM controller.
// - Address bits 23:21 decode the five card modes.
// - Address bit 22 drives card register select except in True IDE, alternate True IDE and undefined modes.
// - Card enables come from byte 0 select and write 1 (fixed in True IDE, alternate True IDE and undefined modes), only inside the card select window.
package ecn_pkg;
    localparam int ADDR_W = 26;
    localparam int BUS_ADDR_W = 32;
    localparam int NUM_CS = 6;
    localparam int MODE_LSB = 21;
    localparam int MODE_MSB = 23;
    localparam int REG_SEL_BIT = 22;
    localparam int ALE_BIT = 21;
    localparam int CLE_BIT = 22;
    localparam int A25_BIT = 25;
    localparam int REGION_LSB = 28;
    localparam int REGION_MSB = 31;
    localparam logic [3:0] FLASH_REGION = 4'h4;
    localparam logic [2:0] MODE_ATTR = 3'h0;
    localparam logic [2:0] MODE_COMMON = 3'h2;
    localparam logic [2:0] MODE_IO = 3'h4;
    localparam logic [2:0] MODE_IDE = 3'h6;
    localparam logic [2:0] MODE_ALT_IDE = 3'h7;
    localparam int CS_BOOT = 0;
    localparam int CS_DRAM = 1;
    localparam int CS_FLASH = 3;
    localparam int CS_CARD0 = 4;
    localparam int CS_CARD1 = 5;
    localparam logic [1:0] DBW_8 = 2'h0;
    localparam logic [1:0] DBW_16 = 2'h1;
    localparam logic [1:0] DBW_32 = 2'h2;
    localparam logic [1:0] RST_CS0_WIDTH = DBW_16;
    localparam logic RST_CS0_BYTE_SELECT = 1'b1;
    localparam logic RST_CS0_RW_BY_CS = 1'b1;
    localparam logic RST_STROBE_N = 1'b1;
    localparam logic [NUM_CS-1:0] RST_CS_N = 6'h3F;

    typedef enum logic [2:0] {
        ecn_mode_attr,
        ecn_mode_common,
        ecn_mode_io,
        ecn_mode_ide,
        ecn_mode_alt_ide,
        ecn_mode_none
    } ecn_card_mode_t;

    function automatic ecn_card_mode_t ecn_decode_mode(input logic [2:0] sel);
        case (sel)
            MODE_ATTR: return ecn_mode_attr;
            MODE_COMMON: return ecn_mode_common;
            MODE_IO: return ecn_mode_io;
            MODE_IDE: return ecn_mode_ide;
            MODE_ALT_IDE: return ecn_mode_alt_ide;
            default: return ecn_mode_none;
        endcase
    endfunction

    function automatic logic ecn_in_flash_region(input logic [BUS_ADDR_W-1:0] a);
        return a[REGION_MSB:REGION_LSB] == FLASH_REGION;
    endfunction
endpackage

// *** hdl/ecn_smc_if.sv ***
interface ecn_smc_if;
    import ecn_pkg::*;
    logic [NUM_CS-1:0] cs_n;
    logic rd_n;
    logic wr0_n;
    logic wr1_n;
    logic wr3_n;
    logic bs0_n;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [BUS_ADDR_W-1:0] bus_addr;
    modport source(output cs_n, rd_n, wr0_n, wr1_n, wr3_n, bs0_n, write, addr, bus_addr);
    modport sink(input cs_n, rd_n, wr0_n, wr1_n, wr3_n, bs0_n, write, addr, bus_addr);
endinterface

// *** tb/ecn_far_model.sv ***
module ecn_far_model (
    input wire logic clock,        // System clock
    input wire logic reset,        // Async reset, high
    input wire logic flash_we_n,   // Flash write enable pin
    input wire logic flash_cle,    // Flash command latch pin
    input wire logic flash_ale,    // Flash address latch pin
    output logic flash_ce_n,       // Flash chip enable from general I/O
    output logic card_wait_n,      // Card wait towards the controller
    output logic [7:0] cmd_count,  // Commands latched
    output logic [7:0] addr_count  // Address cycles latched
);
    logic we_last;
    assign flash_ce_n = 1'h0;
    assign card_wait_n = 1'h1;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            we_last <= 1'h1;
            cmd_count <= 8'h00;
            addr_count <= 8'h00;
        end else begin
            we_last <= flash_we_n;
            // Latch on the rising write edge, as the flash part does
            if (!we_last && flash_we_n && flash_cle) cmd_count <= cmd_count + 8'h01;
            if (!we_last && flash_we_n && flash_ale) addr_count <= addr_count + 8'h01;
        end
    end
endmodule

// *** tb/test_ecn_pin_steering.sv ***
module test_ecn_pin_steering;
    timeunit 1ns;
    timeprecision 1ns;
    import ecn_pkg::*;
    logic clock = 1'h0, reset = 1'h1, dram_cs_n = 1'h1, transfer_write = 1'h0;
    logic cs1_dram_assign_bit = 1'h0, cs3_flash_assign_bit = 1'h0;
    logic cs4_card_assign_bit = 1'h0, cs5_card_assign_bit = 1'h0;
    logic [NUM_CS-1:0] smc_cs_n = 6'h3F, chip_select_n;
    logic static_read_strobe_n = 1'h1, static_write0_strobe_n = 1'h1;
    logic static_write1_byte1_select_n = 1'h1, static_write3_byte3_select_n = 1'h1;
    logic static_byte0_select_n = 1'h1, cs0_mode_load = 1'h0, cs0_byte_select_in = 1'h0;
    logic [ADDR_W-1:0] smc_address = 26'h0;
    logic [BUS_ADDR_W-1:0] bus_address = 32'h0;
    logic [1:0] cs0_bus_width_in = 2'h0, cs0_bus_width;
    logic cs0_rw_by_cs_in = 1'h0, read_or_card_oe_n, write0_or_card_we_n, write1_or_card_ior_n;
    logic write3_or_card_iow_n, addr25_or_card_rnw, card_enable_one_n, card_enable_two_n;
    logic card_register_select_n, flash_output_enable_n, flash_write_enable_n;
    logic flash_addr_latch, flash_cmd_latch, cs0_byte_select_mode, cs0_rw_by_chip_select;
    logic [ADDR_W-2:0] address_out;
    logic [7:0] cmd_count, addr_count;
    int n_errors = 0, checks = 0, cycles = 0;
    ecn_pin_steering dut (.*);
    ecn_far_model far (.clock(clock), .reset(reset), .flash_we_n(flash_write_enable_n),
        .flash_cle(flash_cmd_latch), .flash_ale(flash_addr_latch), .flash_ce_n(),
        .card_wait_n(), .cmd_count(cmd_count), .addr_count(addr_count));
    initial forever #50 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Assign bits order: {cs5 card, cs4 card, cs3 flash, cs1 dram}
    // Strobes order: {read, write0, write1, write3, byte0}
    task automatic put(input logic [3:0] asg, input logic [5:0] cs, input logic [4:0] st,
                       input logic wr, input logic [25:0] a, input logic [31:0] ba);
        @(posedge clock);
        {cs5_card_assign_bit, cs4_card_assign_bit, cs3_flash_assign_bit} <= asg[3:1];
        cs1_dram_assign_bit <= asg[0];
        smc_cs_n <= cs;
        {static_read_strobe_n, static_write0_strobe_n, static_write1_byte1_select_n,
         static_write3_byte3_select_n, static_byte0_select_n} <= st;
        transfer_write <= wr;
        smc_address <= a;
        bus_address <= ba;
        @(posedge clock);
        #1;
    endtask
    // Returns {oe, we, ior, iow, ce1, ce2, reg} for a read (w=0) or write (w=1)
    function automatic logic [6:0] card_exp(input logic [2:0] c, input logic w);
        case (c)
            3'h0, 3'h2: return {w, !w, 1'h1, 1'h1, 1'h0, 1'h1, c[1]};
            3'h4: return {1'h1, 1'h1, w, !w, 1'h0, 1'h1, 1'h0};
            3'h6: return {1'h0, 1'h1, w, !w, 1'h0, 1'h1, 1'h1};
            3'h1, 3'h3, 3'h5: return 7'h7F;
            default: return {1'h0, 1'h1, w, !w, 1'h1, 1'h0, 1'h1};
        endcase
    endfunction
    task automatic card_modes();
        logic [2:0] codes[6] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7, 3'h5};
        for (int i = 0; i < 6; i++) begin
            for (int d = 0; d < 2; d++) begin
                // Reads go through slot 0, writes through slot 1
                put(d ? 4'h8 : 4'h4, d ? 6'h1F : 6'h2F, d ? 5'h16 : 5'h0E, 1'(d),
                    26'(codes[i]) << 21, d ? 32'h6000_0000 : 32'h5000_0000);
                check({read_or_card_oe_n, write0_or_card_we_n, write1_or_card_ior_n,
                    write3_or_card_iow_n, card_enable_one_n, card_enable_two_n,
                    card_register_select_n}, card_exp(codes[i], 1'(d)));
                check(addr25_or_card_rnw, !d);
                check(chip_select_n, d ? 6'h1F : 6'h2F);
                check(address_out, 25'(codes[i]) << 21);
            end
        end
    endtask
    task automatic normal_access();
        put(4'h4, 6'h3B, 5'h0A, 1'h0, 26'h200_0000, 32'h0);
        check({read_or_card_oe_n, write0_or_card_we_n, write1_or_card_ior_n,
            write3_or_card_iow_n, addr25_or_card_rnw}, 5'h0B);
        check({card_enable_one_n, card_enable_two_n}, 2'h3);
        put(4'h0, 6'h2F, 5'h0A, 1'h0, 26'h0, 32'h0);
        check({read_or_card_oe_n, write1_or_card_ior_n, addr25_or_card_rnw}, 3'h0);
        check(chip_select_n, 6'h2F);
    endtask
    task automatic flash_cycles();
        put(4'h2, 6'h37, 5'h17, 1'h1, 26'h40_0000, 32'h4000_0000);
        check({flash_output_enable_n, flash_write_enable_n, flash_cmd_latch,
            flash_addr_latch}, 4'hA);
        put(4'h2, 6'h37, 5'h1F, 1'h1, 26'h40_0000, 32'h4000_0000);
        put(4'h2, 6'h37, 5'h0F, 1'h0, 26'h20_0000, 32'h4FFF_FFFF);
        check({flash_output_enable_n, flash_write_enable_n, flash_cmd_latch,
            flash_addr_latch}, 4'h5);
        put(4'h2, 6'h37, 5'h0F, 1'h0, 26'h20_0000, 32'h5000_0000);
        check({flash_output_enable_n, flash_write_enable_n}, 2'h3);
        put(4'h0, 6'h37, 5'h0F, 1'h0, 26'h20_0000, 32'h4000_0000);
        check({flash_output_enable_n, flash_addr_latch}, 2'h2);
        check(cmd_count, 8'h01);
        check(addr_count, 8'h00);
    endtask
    task automatic dram_and_boot();
        @(posedge clock);
        dram_cs_n <= 1'h0;
        put(4'h1, 6'h3F, 5'h1F, 1'h0, 26'h0, 32'h0);
        check(chip_select_n, 6'h3D);
        put(4'h0, 6'h3F, 5'h1F, 1'h0, 26'h0, 32'h0);
        check(chip_select_n, 6'h3F);
        @(posedge clock);
        {cs0_byte_select_in, cs0_bus_width_in, cs0_rw_by_cs_in} <= 4'h4;
        cs0_mode_load <= 1'h1;
        @(posedge clock);
        cs0_mode_load <= 1'h0;
        @(posedge clock);
        #1;
        check({cs0_byte_select_mode, cs0_bus_width, cs0_rw_by_chip_select}, 4'h4);
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'h0;
        #1;
        check({cs0_byte_select_mode, cs0_bus_width, cs0_rw_by_chip_select}, 4'hB);
        check(chip_select_n, 6'h3F);
        card_modes();
        normal_access();
        flash_cycles();
        dram_and_boot();
        give_verdict();
    end
endmodule
